// ==== src/gpio_pkg.sv ====
// constants shared by the general purpose port and its pin synchroniser
// assumes a single 40 MHz clock domain and a plain-port register access
// Function
// - Pins not routed to a peripheral are driven and sampled by this port.
// - Every pin has its own direction bit, changeable at run time.
// - Separate set and clear writes drive any number of outputs at once.
// - Reads return either the output latch or the live pin levels.
// - After reset every direction bit is clear, so all pins are inputs.
// - Every register accepts byte-wide as well as full-width writes.
// - One write can load the whole output latch at once.
// - A mask register shields chosen bits of the port from set, clear and whole-port writes.
package gpio_pkg;
	localparam int unsigned PORT_W    = 32;
	localparam int unsigned LANES     = PORT_W / 8;
	localparam int unsigned SEL_W     = 3;
	// register selects on the access port
	localparam logic [2:0]  SEL_DIR   = 3'h0;
	localparam logic [2:0]  SEL_MASK  = 3'h1;
	localparam logic [2:0]  SEL_PIN   = 3'h2;
	localparam logic [2:0]  SEL_SET   = 3'h3;
	localparam logic [2:0]  SEL_CLR   = 3'h4;
	// reset values
	localparam logic [31:0] DIR_RST   = 32'h0000_0000;
	localparam logic [31:0] MASK_RST  = 32'h0000_0000;
	localparam logic [31:0] LATCH_RST = 32'h0000_0000;
	localparam logic [31:0] OE_B_RST  = 32'hFFFF_FFFF;
	localparam logic [31:0] ZERO_W    = 32'h0000_0000;

	// widen byte enables to a bit mask
	function automatic logic [31:0] lane_bits(input logic [3:0] be);
		logic [31:0] m;
		m = ZERO_W;
		for (int i = 0; i < LANES; i++) begin
			m[i*8 +: 8] = {8{be[i]}};
		end
		return m;
	endfunction
endpackage

// ==== src/gpio_port.sv ====
// general purpose parallel port: direction, latch, set/clear, mask, pin readback
// assumes the pin mux supplies periph_sel and the peripheral's drive per pin
`timescale 1ns/1ps
module gpio_port
	import gpio_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	// register access
	input  wire logic        acc_wr,
	input  wire logic        acc_rd,
	input  wire logic [2:0]  acc_sel,
	input  wire logic [3:0]  acc_be,
	input  wire logic [31:0] acc_wdata,
	output logic      [31:0] rd_data_ff,
	output logic             rd_valid_ff,
	// peripheral side of the pin mux
	input  wire logic [31:0] periph_sel,
	input  wire logic [31:0] periph_out,
	input  wire logic [31:0] periph_oe_b,
	// device pins
	input  wire logic [31:0] pin_in,
	output logic      [31:0] pin_out_ff,
	output logic      [31:0] pin_oe_b_ff
);
	logic [31:0] dir_ff;
	logic [31:0] mask_ff;
	logic [31:0] latch_ff;
	logic [31:0] lanes;
	logic [31:0] wr_bits;
	logic [31:0] nxt_latch;
	logic [31:0] nxt_rd;
	pin_level_if lvl ();

	// byte-lane merge shared by direction, mask and whole-port writes;
	// one copy keeps the three register paths from drifting apart
	function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [31:0] take);
		return (old_v & ~take) | (new_v & take);
	endfunction

	pin_sync u_sync (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.pin_in  (pin_in),
		.lvl     (lvl)
	);

	// written bits: enabled byte lanes, minus masked pins for data registers
	assign lanes   = lane_bits(acc_be);
	assign wr_bits = lanes & ~mask_ff;

	// direction register, one bit per pin, cleared by reset
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			dir_ff <= DIR_RST;
		end else if (acc_wr && acc_sel == SEL_DIR) begin
			dir_ff <= merge_lanes(dir_ff, acc_wdata, lanes);
		end
	end

	// mask register, byte writable
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			mask_ff <= MASK_RST;
		end else if (acc_wr && acc_sel == SEL_MASK) begin
			mask_ff <= merge_lanes(mask_ff, acc_wdata, lanes);
		end
	end

	// output latch update; zero data bits leave set/clear pins alone
	always_comb begin
		nxt_latch = latch_ff;
		if (acc_wr) begin
			unique case (acc_sel)
				SEL_SET: nxt_latch = latch_ff | (acc_wdata & wr_bits);
				SEL_CLR: nxt_latch = latch_ff & ~(acc_wdata & wr_bits);
				SEL_PIN: nxt_latch = merge_lanes(latch_ff, acc_wdata, wr_bits);
				default: nxt_latch = latch_ff;  // other selects never touch the latch
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			latch_ff <= LATCH_RST;
		end else begin
			latch_ff <= nxt_latch;
		end
	end

	// read mux; masked pins read zero on pin and latch reads, clear reads zero
	always_comb begin
		nxt_rd = ZERO_W;
		unique case (acc_sel)
			SEL_DIR:  nxt_rd = dir_ff;
			SEL_MASK: nxt_rd = mask_ff;
			SEL_PIN:  nxt_rd = lvl.level & ~mask_ff;
			SEL_SET:  nxt_rd = latch_ff & ~mask_ff;
			default:  nxt_rd = ZERO_W;                  // clear and unused selects
		endcase
	end

	// read data is registered, so it arrives one cycle after the strobe
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data_ff  <= ZERO_W;
			rd_valid_ff <= 1'b0;
		end else begin
			rd_data_ff  <= acc_rd ? nxt_rd : ZERO_W;
			rd_valid_ff <= acc_rd;
		end
	end

	// pin drive: peripheral wins on its pins; costs one cycle of latency
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_out_ff  <= LATCH_RST;
			pin_oe_b_ff <= OE_B_RST;
		end else begin
			pin_out_ff  <= (periph_sel & periph_out) | (~periph_sel & latch_ff);
			pin_oe_b_ff <= (periph_sel & periph_oe_b) | (~periph_sel & ~dir_ff);
		end
	end

	chk_reset_inputs: assert property (
		@(posedge ref_clk) $rose(rst_b) |-> (dir_ff == DIR_RST && pin_oe_b_ff == OE_B_RST))
		else $error("pins not inputs after reset");

	chk_set_bits: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		(acc_wr && acc_sel == SEL_SET) |=>
		latch_ff == ($past(latch_ff) | ($past(acc_wdata) & $past(wr_bits))))
		else $error("set write wrong");

	chk_clr_bits: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		(acc_wr && acc_sel == SEL_CLR) |=>
		latch_ff == ($past(latch_ff) & ~($past(acc_wdata) & $past(wr_bits))))
		else $error("clear write wrong");

	chk_whole_write: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		(acc_wr && acc_sel == SEL_PIN && acc_be == 4'hF && mask_ff == ZERO_W) |=>
		latch_ff == $past(acc_wdata))
		else $error("whole port write not loaded");

	chk_no_lane: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		(acc_wr && acc_be == 4'h0) |=> ($stable(latch_ff) && $stable(dir_ff) && $stable(mask_ff)))
		else $error("write with no lanes changed state");

	chk_mask_hold: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		acc_wr |=> ((latch_ff ^ $past(latch_ff)) & $past(mask_ff)) == ZERO_W)
		else $error("masked pin changed");

	chk_pin_drive: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		rst_b |=> pin_oe_b_ff == (($past(periph_sel) & $past(periph_oe_b))
			| (~$past(periph_sel) & ~$past(dir_ff))))
		else $error("pin enable wrong");

	chk_read_pin: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		(acc_rd && acc_sel == SEL_PIN) |=>
		(rd_valid_ff && rd_data_ff == ($past(lvl.level) & ~$past(mask_ff))))
		else $error("pin read wrong");

	chk_read_latch: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		(acc_rd && acc_sel == SEL_SET) |=>
		rd_data_ff == ($past(latch_ff) & ~$past(mask_ff)))
		else $error("latch read wrong");

	// the checks below cover what the bench only sees at read time;
	// antecedents sampled on the release edge still see reset low,
	// so outputs loaded under reset are never held to the run rules
	chk_idle_read: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		(rst_b && !acc_rd) |=> (!rd_valid_ff && rd_data_ff == ZERO_W))
		else $error("read data not quiet between reads");

	chk_clr_read: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		(acc_rd && acc_sel == SEL_CLR) |=> (rd_valid_ff && rd_data_ff == ZERO_W))
		else $error("clear register read not zero");

	chk_masked_read: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		(acc_rd && (acc_sel == SEL_PIN || acc_sel == SEL_SET)) |=>
		(rd_data_ff & $past(mask_ff)) == ZERO_W)
		else $error("masked pin read not zero");

	chk_set_rises: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		(acc_wr && acc_sel == SEL_SET) |=>
		($past(latch_ff) & ~latch_ff) == ZERO_W)
		else $error("set write cleared a pin");

	chk_dir_write: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		(acc_wr && acc_sel == SEL_DIR && acc_be == 4'hF) |=>
		dir_ff == $past(acc_wdata))
		else $error("direction write not loaded");

	// a write elsewhere must never move a pin between input and output
	chk_dir_hold: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		(rst_b && !(acc_wr && acc_sel == SEL_DIR)) |=> $stable(dir_ff))
		else $error("direction changed without a write");

	chk_dir_lanes: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		(acc_wr && acc_sel == SEL_DIR) |=>
		((dir_ff ^ $past(dir_ff)) & ~$past(lanes)) == ZERO_W)
		else $error("direction byte outside enabled lanes changed");

	chk_latch_quiet: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		(rst_b && !acc_wr) |=> $stable(latch_ff))
		else $error("output latch changed without a write");

	chk_periph_out: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		rst_b |=> pin_out_ff == (($past(periph_sel) & $past(periph_out))
			| (~$past(periph_sel) & $past(latch_ff))))
		else $error("pin output value wrong");
endmodule // gpio_port

// ==== src/pin_level_if.sv ====
// carrier for synchronised pin levels between the synchroniser and the port
// assumes both ends sit on ref_clk
`timescale 1ns/1ps
interface pin_level_if;
	logic [31:0] level;
	modport src (output level);
	modport dst (input level);
endinterface : pin_level_if

// ==== src/pin_sync.sv ====
// two-flop synchroniser for the asynchronous pin inputs
// assumes pins may change at any time relative to ref_clk
`timescale 1ns/1ps
module pin_sync
	import gpio_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	// raw pins
	input  wire logic [31:0] pin_in,
	// synchronised levels
	pin_level_if.src         lvl
);
	logic [31:0] meta_ff;
	logic [31:0] sync_ff;

	// first stage feeds only the second stage, to keep metastability contained
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= ZERO_W;
			sync_ff <= ZERO_W;
		end else begin
			meta_ff <= pin_in;
			sync_ff <= meta_ff;
		end
	end

	assign lvl.level = sync_ff;
endmodule // pin_sync

// ==== verification/gpio_port_tb_top.sv ====
// self-checking bench for the general purpose port, reference model in the bench
// assumes gpio_port with plain ports on a 40 MHz ref_clk
`timescale 1ns/1ps
module gpio_port_tb_top
	import gpio_pkg::*;
;
	logic        ref_clk = 1'b0, rst_b = 1'b0, acc_wr = 1'b0, acc_rd = 1'b0, rd_valid_ff;
	logic [2:0]  acc_sel = 3'h0;
	logic [3:0]  acc_be = 4'h0;
	logic [31:0] acc_wdata = 32'h0, periph_sel = 32'h0, periph_out = 32'h0, pin_in = 32'h0;
	logic [31:0] periph_oe_b = 32'hFFFFFFFF, rd_data_ff, pin_out_ff, pin_oe_b_ff;
	logic [31:0] dir, msk, lat, e, r;
	int          miscompares = 0, comparisons = 0, seed = 41, i;

	// 25 ns period
	always #12.5 ref_clk = ~ref_clk;

	gpio_port gpio_port_i (.ref_clk(ref_clk), .rst_b(rst_b), .acc_wr(acc_wr), .acc_rd(acc_rd),
		.acc_sel(acc_sel), .acc_be(acc_be), .acc_wdata(acc_wdata), .rd_data_ff(rd_data_ff),
		.rd_valid_ff(rd_valid_ff), .periph_sel(periph_sel), .periph_out(periph_out),
		.periph_oe_b(periph_oe_b), .pin_in(pin_in), .pin_out_ff(pin_out_ff),
		.pin_oe_b_ff(pin_oe_b_ff));

	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		comparisons++;
		if (g !== x) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, x, g);
		end
	endtask

	// one-cycle write pulse; caller ends it with idle or rd
	task automatic wr(input logic [2:0] s, input logic [3:0] b, input logic [31:0] d);
		logic [31:0] m;
		m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
		@(posedge ref_clk);
		acc_wr <= 1'b1;
		acc_sel <= s;
		acc_be <= b;
		acc_wdata <= d;
		case (s)
			SEL_DIR:  dir = dir & ~m | d & m;
			SEL_MASK: msk = msk & ~m | d & m;
			SEL_PIN:  lat = lat & ~(m & ~msk) | d & m & ~msk;
			SEL_SET:  lat = lat | d & m & ~msk;
			SEL_CLR:  lat = lat & ~(d & m & ~msk);
			default:  ;
		endcase
	endtask

	task automatic idle(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			acc_wr <= 1'b0;
			acc_rd <= 1'b0;
		end
	endtask

	// pin reads need pin_in stable three edges beforehand
	task automatic rd(input logic [2:0] s);
		@(posedge ref_clk);
		acc_wr <= 1'b0;
		acc_rd <= 1'b1;
		acc_sel <= s;
		@(posedge ref_clk);
		acc_rd <= 1'b0;
		#1;
		case (s)
			SEL_DIR:  e = dir;
			SEL_MASK: e = msk;
			SEL_PIN:  e = pin_in & ~msk;
			SEL_SET:  e = lat & ~msk;
			default:  e = 32'h0;
		endcase
		chk("rd_valid_ff", 32'h1, {31'h0, rd_valid_ff});
		chk("rd_data_ff", e, rd_data_ff);
	endtask

	// pin_out only compared where the pin is driven
	task automatic pins;
		idle(2);
		#1;
		e = periph_sel & periph_oe_b | ~periph_sel & ~dir;
		chk("pin_oe_b_ff", e, pin_oe_b_ff);
		chk("pin_out_ff", (periph_sel & periph_out | ~periph_sel & lat) & ~e,
			pin_out_ff & ~e);
		// no read pending, so the read port must sit at zero
		chk("rd_valid_ff", 32'h0, {31'h0, rd_valid_ff});
		chk("rd_data_ff", 32'h0, rd_data_ff);
	endtask

	task automatic conclude;
		if (miscompares == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// directed cases, then random traffic
	initial begin
		dir = 32'h0;
		msk = 32'h0;
		lat = 32'h0;
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'b1;
		#1;
		chk("pin_oe_b_ff", 32'hFFFFFFFF, pin_oe_b_ff);
		rd(SEL_DIR);
		wr(SEL_DIR, 4'hF, 32'h000000FF);
		wr(SEL_SET, 4'hF, 32'h0000000F);
		wr(SEL_CLR, 4'hF, 32'h00000005);
		pins;
		rd(SEL_SET);
		wr(SEL_PIN, 4'h2, 32'hA5A5A5A5);
		wr(SEL_PIN, 4'hF, 32'h12345678);
		wr(SEL_DIR, 4'h0, 32'hFFFFFFFF);
		wr(SEL_MASK, 4'h1, 32'h0000003C);
		wr(SEL_SET, 4'hF, 32'h000000FF);
		pins;
		rd(SEL_SET);
		rd(SEL_PIN);
		rd(SEL_CLR);
		idle(1);
		periph_sel <= 32'h00000F0F;
		periph_out <= 32'h00000A0A;
		periph_oe_b <= 32'h000000FF;
		pins;
		for (i = 0; i < 200; i++) begin
			r = $random(seed);
			if (i % 8 == 0) begin
				idle(1);
				pin_in <= $random(seed);
				periph_sel <= $random(seed) & $random(seed);
				periph_out <= $random(seed);
				periph_oe_b <= $random(seed);
				idle(4);
			end
			case (r[9:8])
				2'h0, 2'h1: wr(r[2:0], r[6:3], $random(seed));
				2'h2:       rd(r[2:0]);
				default:    pins;
			endcase
		end
		// reset again mid-run: every pin must fall back to input
		idle(1);
		rst_b <= 1'b0;
		dir = 32'h0;
		msk = 32'h0;
		lat = 32'h0;
		idle(2);
		rst_b <= 1'b1;
		#1;
		chk("pin_oe_b_ff", 32'hFFFFFFFF, pin_oe_b_ff);
		rd(SEL_DIR);
		rd(SEL_SET);
		pins;
		idle(1);
		conclude;
	end

	// cuts a hang short
	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		conclude;
	end
endmodule // gpio_port_tb_top
